// ### core/prpd_ctrl.sv
// Contract
// [RQ1] reset pulse runs at power-on configuration and on every reconfiguration
// [RQ2] pin-select bits 2:1: 0 none, 1 serial data, 2 mosi, 3 audio pin
// [RQ3] transmitter register bit 0: 0 pulse active low, 1 active high
// [RQ4] reset pulse lasts about 285 us then returns inactive
// [RQ5] receiver side has its own independent reset output register
// [RQ6] host should keep reset output settings in configuration memory
// [RQ7] power down entered by host request or automatically after link loss
// [RQ8] host sets receiver power down bit before transmitter power down bit
// [RQ9] no power down unless that side's wake interval timer is nonzero
// [RQ10] writing 0x01 to remote command starts transfer; receiver sleeps on completion
// [RQ11] host keeps serial control interfaces idle when entering power down
// [RQ12] link loss starts timeout; power down if no link when it expires
// [RQ13] automatic power down enabled only with nonzero wake interval timer
// [RQ14] timeout is (high byte*256 + low byte) times 10 ms per side
// [RQ15] while timeout runs, other power down requests are ignored
// [RQ16] zero wake timer prevents power down; nonzero counts 10 ms periods
// [RQ17] pin-select zero gives no pulse and pins keep normal function
// [RQ18] selected reset pin sits at inactive level outside the pulse
`timescale 1ns/100ps
`default_nettype none
module prpd_ctrl #(
  parameter int unsigned TICK_CYCLES      = prpd_pkg::TICK_CYCLES,
  parameter int unsigned RST_PULSE_CYCLES = prpd_pkg::RST_PULSE_CYCLES
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // radio link status pins, one per side
  input  wire logic [1:0]  link_up,
  // remote settings transfer
  input  wire logic        remote_xfer_done,
  output logic             remote_xfer_start,
  // power down outputs, one per side
  output logic      [1:0]  power_down,
  // reset pins per side: bit 0 serial data, 1 mosi, 2 audio pin
  output logic      [2:0]  tx_rst_pin_val,
  output logic      [2:0]  tx_rst_pin_en,
  output logic      [2:0]  rx_rst_pin_val,
  output logic      [2:0]  rx_rst_pin_en
);

  localparam int unsigned NS = prpd_pkg::NUM_SIDES;

  typedef enum logic [3:0] {
    PRPD_R_NONE     = 4'h0,
    PRPD_R_RESO     = 4'h1,
    PRPD_R_MODE     = 4'h2,
    PRPD_R_WAKE     = 4'h3,
    PRPD_R_SLEEP    = 4'h4,
    PRPD_R_CMD      = 4'h5,
    PRPD_R_STATUS   = 4'h6,
    PRPD_R_RECONFIG = 4'h7
  } prpd_reg_t;

  // register kind of an address
  function automatic prpd_reg_t reg_kind(input logic [7:0] a);
    case (a)
      prpd_pkg::ADDR_TX_RESO, prpd_pkg::ADDR_RX_RESO:   reg_kind = PRPD_R_RESO;
      prpd_pkg::ADDR_TX_MODE, prpd_pkg::ADDR_RX_MODE:   reg_kind = PRPD_R_MODE;
      prpd_pkg::ADDR_TX_WAKE, prpd_pkg::ADDR_RX_WAKE:   reg_kind = PRPD_R_WAKE;
      prpd_pkg::ADDR_TX_SLEEP, prpd_pkg::ADDR_RX_SLEEP: reg_kind = PRPD_R_SLEEP;
      prpd_pkg::ADDR_REMOTE_CMD:                        reg_kind = PRPD_R_CMD;
      prpd_pkg::ADDR_STATUS:                            reg_kind = PRPD_R_STATUS;
      prpd_pkg::ADDR_RECONFIG:                          reg_kind = PRPD_R_RECONFIG;
      default:                                          reg_kind = PRPD_R_NONE;
    endcase
  endfunction

  // side of an address
  function automatic logic reg_side(input logic [7:0] a);
    case (a)
      prpd_pkg::ADDR_RX_RESO, prpd_pkg::ADDR_RX_MODE,
      prpd_pkg::ADDR_RX_WAKE, prpd_pkg::ADDR_RX_SLEEP: reg_side = 1'b1;
      default:                                         reg_side = 1'b0;
    endcase
  endfunction

  // bus state
  logic             wr_q;
  logic             rd_q;
  logic [7:0]       addr_q;
  logic [31:0]      hrdata_q;
  logic             hreadyout_q;

  // registers
  logic [7:0]       reso_q  [NS];
  logic [7:0]       mode_q  [NS];
  logic [7:0]       wake_q  [NS];
  logic [15:0]      sleep_q [NS];
  logic             xfer_pend_q;
  logic             xfer_start_q;
  logic             cfg_req_q;

  // pulse and side state
  logic             pulse_q;
  logic [19:0]      pulse_cnt_q;
  logic [NS-1:0]    link_m_q;
  logic [NS-1:0]    link_s_q;
  logic [NS-1:0]    link_prev_q;
  logic [NS-1:0]    auto_q;
  logic [NS-1:0]    pd_q;
  logic [2:0]       pin_val_q [NS];
  logic [2:0]       pin_en_q  [NS];

  logic             addr_take;
  logic             wr_fire;
  prpd_reg_t        wr_kind;
  logic             wr_side;

  assign addr_take = hsel & hready & htrans[1];
  assign wr_fire   = wr_q;
  assign wr_kind   = reg_kind(addr_q);
  assign wr_side   = reg_side(addr_q);

  // address phase capture; reads take one wait state, writes none
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q        <= 1'b0;
      rd_q        <= 1'b0;
      addr_q      <= 8'h00;
      hreadyout_q <= 1'b1;
    end else begin
      if (rd_q) begin
        rd_q        <= 1'b0;
        hreadyout_q <= 1'b1;
        wr_q        <= 1'b0;
      end else begin
        wr_q        <= addr_take & hwrite;
        rd_q        <= addr_take & ~hwrite;
        hreadyout_q <= ~(addr_take & ~hwrite);
        if (addr_take) begin
          addr_q <= {haddr[7:2], 2'b00};
        end
      end
    end
  end

  // read data, unmapped addresses read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_q) begin
      unique case (reg_kind(addr_q))
        PRPD_R_RESO:   hrdata_q <= {24'h00_0000, reso_q[reg_side(addr_q)]};
        PRPD_R_MODE:   hrdata_q <= {24'h00_0000, mode_q[reg_side(addr_q)]};
        PRPD_R_WAKE:   hrdata_q <= {24'h00_0000, wake_q[reg_side(addr_q)]};
        PRPD_R_SLEEP:  hrdata_q <= {16'h0000, sleep_q[reg_side(addr_q)]};
        PRPD_R_STATUS: hrdata_q <= {24'h00_0000, xfer_pend_q, pulse_q,
                                    link_s_q, auto_q, pd_q};
        PRPD_R_CMD, PRPD_R_RECONFIG, PRPD_R_NONE: hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // per side configuration registers
  for (genvar s = 0; s < NS; s++) begin : g_regs
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        reso_q[s]  <= prpd_pkg::RESO_RST;
        mode_q[s]  <= prpd_pkg::MODE_RST;
        wake_q[s]  <= prpd_pkg::WAKE_RST;
        sleep_q[s] <= prpd_pkg::SLEEP_RST;
      end else if (wr_fire && (wr_side == 1'(s))) begin
        unique case (wr_kind)
          PRPD_R_RESO:  reso_q[s]  <= hwdata[7:0] & prpd_pkg::RESO_WMASK; // [RQ5]
          PRPD_R_MODE:  mode_q[s]  <= hwdata[7:0];
          PRPD_R_WAKE:  wake_q[s]  <= hwdata[7:0];
          PRPD_R_SLEEP: sleep_q[s] <= hwdata[15:0];
          default:      reso_q[s]  <= reso_q[s];
        endcase
      end
    end
  end

  // remote settings transfer request; a new request wins over a completion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_pend_q  <= 1'b0;
      xfer_start_q <= 1'b0;
    end else begin
      xfer_start_q <= wr_fire && (wr_kind == PRPD_R_CMD) &&
                      (hwdata[7:0] == prpd_pkg::REMOTE_CMD_XFER); // [RQ10]
      if (wr_fire && (wr_kind == PRPD_R_CMD) &&
          (hwdata[7:0] == prpd_pkg::REMOTE_CMD_XFER)) begin
        xfer_pend_q <= 1'b1; // [RQ10]
      end else if (remote_xfer_done) begin
        xfer_pend_q <= 1'b0;
      end
    end
  end

  // configuration routine request: set at reset, again on reconfigure
  // a reconfigure landing during a pulse is held and reruns it afterwards
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_req_q <= 1'b1; // [RQ1]
    end else if (wr_fire && (wr_kind == PRPD_R_RECONFIG) &&
                 hwdata[prpd_pkg::RECONFIG_BIT]) begin
      cfg_req_q <= 1'b1; // [RQ1]
    end else if (!pulse_q) begin
      cfg_req_q <= 1'b0;
    end
  end

  // reset pulse timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_q     <= 1'b0;
      pulse_cnt_q <= 20'h0_0000;
    end else if (cfg_req_q && !pulse_q) begin
      pulse_q     <= 1'b1; // [RQ1]
      pulse_cnt_q <= 20'h0_0000;
    end else if (pulse_q) begin
      if (pulse_cnt_q == 20'(RST_PULSE_CYCLES - 1)) begin
        pulse_q <= 1'b0; // [RQ4]
      end
      pulse_cnt_q <= pulse_cnt_q + 20'h0_0001;
    end
  end

  // per side reset pins and power down control
  for (genvar s = 0; s < NS; s++) begin : g_side
    logic [prpd_pkg::RESO_SEL_W-1:0] sel;
    logic                            pol;
    logic                            wake_nz;
    logic                            pd_bit;
    logic                            man_req;
    logic                            pd_clr;
    logic [20:0]                     tick_cnt_q;
    logic [15:0]                     ticks_q;

    assign sel     = reso_q[s][prpd_pkg::RESO_SEL_LSB +: prpd_pkg::RESO_SEL_W]; // [RQ2]
    assign pol     = reso_q[s][prpd_pkg::RESO_POL_BIT]; // [RQ3]
    assign wake_nz = (wake_q[s] != 8'h00); // [RQ9] [RQ13] [RQ16]
    assign pd_bit  = (s == prpd_pkg::SIDE_TX) ? mode_q[s][prpd_pkg::TX_MODE_PD_BIT]
                                             : mode_q[s][prpd_pkg::RX_MODE_PD_BIT];
    // receiver sleeps when its settings transfer completes
    assign man_req = (s == prpd_pkg::SIDE_TX) ? pd_bit
                   : (pd_bit & remote_xfer_done & xfer_pend_q); // [RQ8] [RQ10]
    assign pd_clr  = wr_fire && (wr_kind == PRPD_R_MODE) && (wr_side == 1'(s)) &&
                     !((s == prpd_pkg::SIDE_TX) ? hwdata[prpd_pkg::TX_MODE_PD_BIT]
                                               : hwdata[prpd_pkg::RX_MODE_PD_BIT]);

    for (genvar p = 0; p < 3; p++) begin : g_pin
      logic hit;
      assign hit = (sel == 2'(p + 1)); // [RQ2]

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_en_q[s][p]  <= 1'b0;
          pin_val_q[s][p] <= 1'b0;
        end else begin
          pin_en_q[s][p]  <= hit; // [RQ2] [RQ17]
          pin_val_q[s][p] <= hit && (pulse_q ? pol : ~pol); // [RQ3] [RQ18]
        end
      end
    end

    // link status synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        link_m_q[s]    <= 1'b0;
        link_s_q[s]    <= 1'b0;
        link_prev_q[s] <= 1'b0;
      end else begin
        link_m_q[s]    <= link_up[s];
        link_s_q[s]    <= link_m_q[s];
        link_prev_q[s] <= link_s_q[s];
      end
    end

    // 10 ms timebase restarted with each timeout
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        tick_cnt_q <= 21'h00_0000;
        ticks_q    <= 16'h0000;
      end else if (!auto_q[s]) begin
        tick_cnt_q <= 21'h00_0000;
        ticks_q    <= 16'h0000;
      end else if (tick_cnt_q == 21'(TICK_CYCLES - 1)) begin
        tick_cnt_q <= 21'h00_0000;
        ticks_q    <= ticks_q + 16'h0001; // [RQ14]
      end else begin
        tick_cnt_q <= tick_cnt_q + 21'h00_0001;
      end
    end

    // automatic timeout and power down state
    // a running timeout shuts out mode-bit requests until it expires or the link returns
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        auto_q[s] <= 1'b0;
        pd_q[s]   <= 1'b0;
      end else if (auto_q[s]) begin
        if (link_s_q[s]) begin
          auto_q[s] <= 1'b0; // [RQ12]
        // a sleep value of zero ends the timeout on its first cycle
        end else if (ticks_q >= sleep_q[s]) begin
          auto_q[s] <= 1'b0;
          pd_q[s]   <= 1'b1; // [RQ12] [RQ14] [RQ15]
        end
      end else if (!pd_q[s] && link_prev_q[s] && !link_s_q[s] && wake_nz) begin
        auto_q[s] <= 1'b1; // [RQ7] [RQ12] [RQ13]
      end else if (!pd_q[s] && man_req && wake_nz) begin
        pd_q[s] <= 1'b1; // [RQ7] [RQ9]
      end else if (pd_clr) begin
        pd_q[s] <= 1'b0;
      end
    end
  end

  assign hrdata            = hrdata_q;
  assign hreadyout         = hreadyout_q;
  assign hresp             = 1'b0;
  assign remote_xfer_start = xfer_start_q;
  assign power_down        = pd_q;
  assign tx_rst_pin_val    = pin_val_q[prpd_pkg::SIDE_TX];
  assign tx_rst_pin_en     = pin_en_q[prpd_pkg::SIDE_TX];
  assign rx_rst_pin_val    = pin_val_q[prpd_pkg::SIDE_RX];
  assign rx_rst_pin_en     = pin_en_q[prpd_pkg::SIDE_RX];

  // bus inputs that carry nothing for word-only registers
  logic unused_ok;
  assign unused_ok = ^{hsize, hwdata[31:16]};

endmodule
`default_nettype wire

// ### shared/prpd_pkg.sv
`default_nettype none
package prpd_pkg;

  // side indices
  localparam int unsigned SIDE_TX = 0;
  localparam int unsigned SIDE_RX = 1;
  localparam int unsigned NUM_SIDES = 2;

  // register byte addresses
  localparam logic [7:0] ADDR_RX_RESO     = 8'h40;
  localparam logic [7:0] ADDR_TX_RESO     = 8'h50;
  localparam logic [7:0] ADDR_TX_MODE     = 8'h60;
  localparam logic [7:0] ADDR_RX_MODE     = 8'h64;
  localparam logic [7:0] ADDR_TX_WAKE     = 8'h68;
  localparam logic [7:0] ADDR_RX_WAKE     = 8'h6c;
  localparam logic [7:0] ADDR_TX_SLEEP    = 8'h70;
  localparam logic [7:0] ADDR_RX_SLEEP    = 8'h74;
  localparam logic [7:0] ADDR_REMOTE_CMD  = 8'h78;
  localparam logic [7:0] ADDR_STATUS      = 8'h7c;
  localparam logic [7:0] ADDR_RECONFIG    = 8'h80;

  // reset output register fields
  localparam int unsigned RESO_POL_BIT = 0;
  localparam int unsigned RESO_SEL_LSB = 1;
  localparam int unsigned RESO_SEL_W   = 2;
  localparam logic [7:0]  RESO_WMASK   = 8'h07;

  // mode register power down bits
  localparam int unsigned TX_MODE_PD_BIT = 6;
  localparam int unsigned RX_MODE_PD_BIT = 7;

  // remote command and reconfigure
  localparam logic [7:0]  REMOTE_CMD_XFER = 8'h01;
  localparam int unsigned RECONFIG_BIT    = 0;

  // reset values
  localparam logic [7:0]  RESO_RST  = 8'h00;
  localparam logic [7:0]  MODE_RST  = 8'h00;
  localparam logic [7:0]  WAKE_RST  = 8'h00;
  localparam logic [15:0] SLEEP_RST = 16'h0000;

  // timing
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned CLK_FREQ_KHZ    = 125000;
  localparam int unsigned TICK_PERIOD_MS  = 10;
  localparam int unsigned RST_PULSE_NS    = 285000;
  localparam int unsigned TICK_CYCLES     = TICK_PERIOD_MS * CLK_FREQ_KHZ;
  localparam int unsigned RST_PULSE_CYCLES =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // status bits
  localparam int unsigned ST_PD_LSB     = 0;
  localparam int unsigned ST_AUTO_LSB   = 2;
  localparam int unsigned ST_LINK_LSB   = 4;
  localparam int unsigned ST_PULSE_BIT  = 6;
  localparam int unsigned ST_XFER_BIT   = 7;

endpackage
`default_nettype wire

// ### verif/prpd_link_model.sv
`timescale 1ns/100ps
`default_nettype none
module prpd_link_model #(
  parameter int unsigned XFER_DLY = 6
) (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // requests from bench and design
  input  wire logic [1:0] link_cmd,
  input  wire logic       remote_xfer_start,
  // answers toward design
  output logic      [1:0] link_up,
  output logic            remote_xfer_done
);
  logic [7:0] cnt_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_up <= 2'h3;
      cnt_q <= 8'h00;
      remote_xfer_done <= 1'b0;
    end else begin
      link_up <= link_cmd;
      cnt_q <= remote_xfer_start ? 8'(XFER_DLY) : cnt_q - 8'(cnt_q != 8'h00);
      remote_xfer_done <= cnt_q == 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### verif/prpd_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none
module prpd_ctrl_checker (
  // clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // link, power down and reset pins
  input wire logic [1:0]  link_up,
  input wire logic        remote_xfer_done,
  input wire logic        remote_xfer_start,
  input wire logic [1:0]  power_down,
  input wire logic [2:0]  tx_rst_pin_val,
  input wire logic [2:0]  tx_rst_pin_en,
  input wire logic [2:0]  rx_rst_pin_val,
  input wire logic [2:0]  rx_rst_pin_en
);
  logic       dw_q;
  logic [7:0] da_q;
  wire logic  rd_req = hsel && hready && htrans[1] && !hwrite;
  wire logic  clr_tx = dw_q && hready && da_q == prpd_pkg::ADDR_TX_MODE && !hwdata[6];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dw_q <= 1'b0;
      da_q <= 8'h00;
    end else if (hready) begin
      dw_q <= hsel && htrans[1] && hwrite;
      da_q <= haddr;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_tx_off; (tx_rst_pin_val & ~tx_rst_pin_en) == 3'h0; endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx pin driven while unused");
  property p_rx_off; (rx_rst_pin_val & ~rx_rst_pin_en) == 3'h0; endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx pin driven while unused");
  property p_sel; $onehot0(tx_rst_pin_en) && $onehot0(rx_rst_pin_en); endproperty
  a_sel: assert property (p_sel) else $error("more than one reset pin");
  property p_start; remote_xfer_start |=> !remote_xfer_start; endproperty
  a_start: assert property (p_start) else $error("start pulse too long");
  property p_rdy; !hreadyout |=> hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state too long");
  property p_rdwait; rd_req |=> !hreadyout; endproperty
  a_rdwait: assert property (p_rdwait) else $error("read without wait state");
  property p_stand; $past(hreadyout) |-> $stable(hrdata); endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
  property p_pd_off; $fell(power_down[0]) |-> $past(clr_tx) || $past(clr_tx, 2); endproperty
  a_pd_off: assert property (p_pd_off) else $error("tx left power down");
  property p_rx_pd;
    $rose(power_down[1]) |-> $past(remote_xfer_done) || !$past(link_up[1], 3);
  endproperty
  a_rx_pd: assert property (p_rx_pd) else $error("rx power down uncaused");
  c_rd: cover property (rd_req);
  c_pd: cover property ($rose(power_down[0]));
  c_xfer: cover property (remote_xfer_done);
endmodule
bind prpd_ctrl prpd_ctrl_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_up(link_up),
  .remote_xfer_done(remote_xfer_done), .remote_xfer_start(remote_xfer_start),
  .power_down(power_down), .tx_rst_pin_val(tx_rst_pin_val), .tx_rst_pin_en(tx_rst_pin_en),
  .rx_rst_pin_val(rx_rst_pin_val), .rx_rst_pin_en(rx_rst_pin_en));
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int unsigned TK = 20;
  localparam int unsigned PW = 10;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, xd, xs;
  logic [7:0]  haddr;
  logic [1:0]  htrans, link_cmd, link_up, pd;
  logic [2:0]  hsize, tv, te, rv, re;
  logic [31:0] hwdata, hrdata, rd;
  int          fail_count, tests_run;
  int          cyc_n = 0;
  prpd_ctrl #(.TICK_CYCLES(TK), .RST_PULSE_CYCLES(PW)) u_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .link_up(link_up), .remote_xfer_done(xd), .remote_xfer_start(xs),
    .power_down(pd), .tx_rst_pin_val(tv), .tx_rst_pin_en(te), .rx_rst_pin_val(rv),
    .rx_rst_pin_en(re));
  prpd_link_model u_link (.hclk(hclk), .hresetn(hresetn), .link_cmd(link_cmd),
    .remote_xfer_start(xs), .link_up(link_up), .remote_xfer_done(xd));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) cyc_n <= cyc_n + 1;
  task automatic test_done;
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tmo;
    fail_count++;
    test_done;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      cyc(1);
      n++;
      if (n > 50) tmo;
    end while (hreadyout !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  task automatic wait_pd(input logic [1:0] v, input int lim);
    int n;
    n = 0;
    while (pd !== v) begin
      cyc(1);
      n++;
      if (n > lim) tmo;
    end
  endtask
  task automatic s_on;
    logic [2:0] e;
    e = 3'h0;
    repeat (2 * PW) begin
      cyc(1);
      e = e | te | re;
    end
    chk("pins at start", 32'(e), 32'h0);
  endtask
  task automatic s_regs;
    bus(0, prpd_pkg::ADDR_RX_RESO, 32'h0);
    chk("rx cfg reset", rd, 32'h0);
    bus(1, prpd_pkg::ADDR_TX_RESO, 32'hff);
    bus(1, prpd_pkg::ADDR_RX_RESO, 32'h5);
    bus(0, prpd_pkg::ADDR_TX_RESO, 32'h0);
    chk("tx cfg upper bits", rd, 32'h7);
    bus(0, prpd_pkg::ADDR_RX_RESO, 32'h0);
    chk("rx cfg", rd, 32'h5);
    bus(0, 8'h44, 32'h0);
    chk("unmapped read", rd, 32'h0);
  endtask
  task automatic s_pulse;
    int n;
    logic [2:0] m, mr, act;
    for (int k = 0; k < 8; k++) begin
      m = (k < 2) ? 3'h0 : 3'h1 << (k / 2 - 1);
      mr = (k > 5) ? 3'h0 : 3'h1 << (2 - k / 2);
      act = k[0] ? m : 3'h0;
      bus(1, prpd_pkg::ADDR_TX_RESO, 32'(k));
      bus(1, prpd_pkg::ADDR_RX_RESO, 32'(7 - k));
      cyc(2);
      chk("tx idle pins", 32'({te, tv}), 32'({m, m & ~act}));
      chk("rx pin select", 32'(re), 32'(mr));
      bus(1, prpd_pkg::ADDR_RECONFIG, 32'h1);
      n = 0;
      while (m != 3'h0 && tv !== act) begin
        cyc(1);
        n++;
        if (n > 8) tmo;
      end
      if (m != 3'h0) chk("rx pulse level", 32'(rv), 32'(k[0] ? 3'h0 : mr));
      n = 0;
      while (m != 3'h0 && tv === act && n < 3 * PW) begin
        cyc(1);
        n++;
      end
      chk("pulse length", n, (m != 3'h0) ? PW : 0);
      chk("tx after pulse", 32'({te, tv}), 32'({m, m & ~act}));
      if (m == 3'h0) cyc(PW + 2);
    end
  endtask
  task automatic s_host;
    bus(1, prpd_pkg::ADDR_RX_WAKE, 32'h0);
    bus(1, prpd_pkg::ADDR_RX_MODE, 32'h80);
    bus(1, prpd_pkg::ADDR_REMOTE_CMD, 32'h1);
    cyc(20);
    chk("rx pd without wake", 32'(pd), 32'h0);
    bus(1, prpd_pkg::ADDR_RX_WAKE, 32'h1);
    bus(1, prpd_pkg::ADDR_REMOTE_CMD, 32'h1);
    wait_pd(2'h2, 30);
    chk("rx pd", 32'(pd), 32'h2);
    bus(1, prpd_pkg::ADDR_TX_WAKE, 32'h0);
    bus(1, prpd_pkg::ADDR_TX_MODE, 32'h40);
    cyc(5);
    chk("tx pd without wake", 32'(pd), 32'h2);
    bus(1, prpd_pkg::ADDR_TX_WAKE, 32'h1);
    bus(1, prpd_pkg::ADDR_TX_MODE, 32'h40);
    cyc(3);
    chk("tx pd", 32'(pd), 32'h3);
    bus(0, prpd_pkg::ADDR_STATUS, 32'h0);
    chk("status", rd, 32'h33);
    bus(1, prpd_pkg::ADDR_TX_MODE, 32'h0);
    bus(1, prpd_pkg::ADDR_RX_MODE, 32'h0);
    cyc(2);
    chk("pd cleared", 32'(pd), 32'h0);
  endtask
  task automatic s_auto;
    int t;
    logic [15:0] s;
    for (int i = 0; i < 2; i++) begin
      s = i ? 16'h0101 : 16'h0003;
      bus(1, prpd_pkg::ADDR_TX_SLEEP, 32'(s));
      t = cyc_n;
      link_cmd <= 2'h2;
      cyc(10);
      bus(1, prpd_pkg::ADDR_TX_MODE, 32'h40);
      cyc(30);
      chk("pd during timeout", 32'(pd), 32'h0);
      wait_pd(2'h1, 6000);
      chk("timeout length", 32'(cyc_n - t - s * TK < 12), 32'h1);
      link_cmd <= 2'h3;
      bus(1, prpd_pkg::ADDR_TX_MODE, 32'h0);
    end
    bus(1, prpd_pkg::ADDR_TX_SLEEP, 32'h3);
    link_cmd <= 2'h2;
    cyc(30);
    link_cmd <= 2'h3;
    cyc(60);
    chk("link back cancels", 32'(pd), 32'h0);
    bus(1, prpd_pkg::ADDR_TX_WAKE, 32'h0);
    link_cmd <= 2'h2;
    cyc(90);
    chk("no auto without wake", 32'(pd), 32'h0);
  endtask
  initial begin
    fail_count = 0;
    tests_run = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    link_cmd = 2'h3;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    s_on;
    s_regs;
    s_pulse;
    s_host;
    s_auto;
    test_done;
  end
endmodule
`default_nettype wire
